// ### pkg/ucs_pkg.sv
// constants, types and state layout of the usart control and status block
// assumes one 100 MHz core clock and a plain single-cycle register port
//
// Contract
// - frame length code 00 gives eight, 01 seven, 10 nine data bits
// - code 11 loops transmitter output into receiver, nine-bit framing
// - parity is extra to data length; generated on transmit, checked on receive; left out with nine data bits
// - global error flag is the read-only or of overrun, framing, parity
// - receive-full sets on buffer load, clears on buffer read, zero at reset
// - transmit-empty sets on move to shifter, clears on buffer write, one at reset
// - error flags set on error, clear on status read and reset
// - received ninth data bit held in read-only bit, zero at reset
// - attention bit writable, cleared by received character with ninth bit set
// - transmitting flag set while sending, clears at end of final stop bit
// - receive-line flag sets on framing error, clears once input is high
// - stop count bit selects one or two transmitted stop bits
// - short stop bit makes last stop bit seven eighths long; no effect in synchronous mode
// - transmit pin enable hands the output pin to the transmitter
// - mode bit selects asynchronous at 0, synchronous at 1, zero at reset
// - receiver clock from internal divider at 0, external pin at 1
// - transmitter clock from internal divider at 0, external pin at 1
// - receive interrupt enable gates the receiver interrupt, zero at reset
// - transmit interrupt enable gates the transmitter interrupt, zero at reset
// - transmit interrupt pending exactly while empty flag and enable set
// - receive interrupt pending exactly while full flag and enable set
// - asynchronous clock is sixteen times bit rate, synchronous equals bit rate
package ucs_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_TX_BUF  = 8'hb8;
  localparam logic [ADDR_W-1:0] ADDR_RX_BUF  = 8'hb9;
  localparam logic [ADDR_W-1:0] ADDR_TX_CTRL = 8'hba;
  localparam logic [ADDR_W-1:0] ADDR_RX_STAT = 8'hbb;
  localparam logic [ADDR_W-1:0] ADDR_CFG     = 8'hbc;

  // usart_tx_control fields
  localparam int unsigned CTL_PAR_EN   = 7;
  localparam int unsigned CTL_PSEL1    = 6;
  localparam int unsigned CTL_XBIT9    = 5;
  localparam int unsigned CTL_FLEN_HI  = 4;
  localparam int unsigned CTL_FLEN_LO  = 3;
  localparam int unsigned CTL_ERR      = 2;
  localparam int unsigned CTL_RX_FULL  = 1;
  localparam int unsigned CTL_TX_EMPTY = 0;

  // usart_rx_status fields
  localparam int unsigned STA_OVR     = 7;
  localparam int unsigned STA_FRM     = 6;
  localparam int unsigned STA_PAR     = 5;
  localparam int unsigned STA_SPARE   = 4;
  localparam int unsigned STA_NINTH   = 3;
  localparam int unsigned STA_ATTENTION_ENABLE    = 2;
  localparam int unsigned STA_TX_ACT  = 1;
  localparam int unsigned STA_RX_LINE = 0;

  // usart_irq_clock_config fields
  localparam int unsigned CFG_TWO_STOP   = 7;
  localparam int unsigned CFG_SHORT_STOP = 6;
  localparam int unsigned CFG_PIN_EN     = 5;
  localparam int unsigned CFG_SYNC       = 4;
  localparam int unsigned CFG_RX_EXT     = 3;
  localparam int unsigned CFG_TX_EXT     = 2;
  localparam int unsigned CFG_RX_IE      = 1;
  localparam int unsigned CFG_TX_IE      = 0;

  localparam logic [DATA_W-1:0] RST_CFG      = 8'h00;
  localparam logic              RST_TX_EMPTY = 1'b1;

  // frame length codes
  localparam logic [1:0] FLEN_8    = 2'h0;
  localparam logic [1:0] FLEN_7    = 2'h1;
  localparam logic [1:0] FLEN_9    = 2'h2;
  localparam logic [1:0] FLEN_LOOP = 2'h3;

  localparam logic [3:0] NBITS_7 = 4'h7;
  localparam logic [3:0] NBITS_8 = 4'h8;
  localparam logic [3:0] NBITS_9 = 4'h9;

  // parity select codes
  localparam logic [1:0] PSEL_ODD   = 2'h0;
  localparam logic [1:0] PSEL_EVEN  = 2'h1;
  localparam logic [1:0] PSEL_MARK  = 2'h2;

  // last tick index within a bit
  localparam logic [3:0] OVS_LAST   = 4'hf;
  localparam logic [3:0] SYNC_LAST  = 4'h0;
  localparam logic [3:0] SHORT_LAST = 4'hd;
  localparam logic [3:0] HALF_LAST  = 4'h7;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ucs_tx_state_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ucs_rx_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ucs_bus_req_s;

  typedef struct packed {
    ucs_tx_state_e     tx_state;
    ucs_rx_state_e     rx_state;
    logic [DATA_W-1:0] cfg;
    logic              par_en;
    logic              psel1;
    logic              xbit9;
    logic [1:0]        flen;
    logic              tx_empty;
    logic              rx_full;
    logic              ovr;
    logic              frm;
    logic              par_err;
    logic              spare;
    logic              ninth;
    logic              attention_enable;
    logic              tx_act;
    logic              rx_line;
    logic [DATA_W-1:0] tx_buffer;
    logic [DATA_W-1:0] rx_buffer;
    logic [8:0]        tx_shift;
    logic              tx_par;
    logic [3:0]        tx_bit_cnt;
    logic [3:0]        tx_sub;
    logic              tx_stop_cnt;
    logic              tx_out;
    logic [8:0]        rx_shift;
    logic              rx_par;
    logic [3:0]        rx_bit_cnt;
    logic [3:0]        rx_sub;
    logic [DATA_W-1:0] rdata;
    logic [2:0]        ck_sync;
    logic              ck_lvl;
    logic [2:0]        din_sync;
    logic              din_lvl;
  } ucs_state_s;

endpackage : ucs_pkg

// ### verilog/ucs_core.sv
// usart control and status logic with a compact transmitter and receiver
// assumes baud_tick_i is a one-cycle enable from an outside divider on core_clk_i
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
module ucs_core (
  // clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      srst_i,
  // register port
  input  wire ucs_pkg::ucs_bus_req_s     bus_i,
  output logic [ucs_pkg::DATA_W-1:0]     rdata_o,
  // baud enable from the internal divider
  input  wire logic                      baud_tick_i,
  // serial pins
  input  wire logic                      serial_in_pin_i,
  input  wire logic                      serial_clock_pin_i,
  output logic                           serial_out_pin_o,
  output logic                           serial_out_pin_oe_o,
  // interrupt requests
  output logic                           rx_irq_o,
  output logic                           tx_irq_o
);

  ucs_pkg::ucs_state_s st_q;
  ucs_pkg::ucs_state_s st_d;

  function automatic logic [3:0] ucs_nbits(input logic [1:0] flen);
    case (flen)
      ucs_pkg::FLEN_8: ucs_nbits = ucs_pkg::NBITS_8;
      ucs_pkg::FLEN_7: ucs_nbits = ucs_pkg::NBITS_7;
      default:         ucs_nbits = ucs_pkg::NBITS_9;
    endcase
  endfunction : ucs_nbits

  function automatic logic ucs_parity(input logic [1:0] psel, input logic [8:0] data, input logic [3:0] nbits);
    logic [8:0] masked;
    masked = (nbits == ucs_pkg::NBITS_7) ? {2'h0, data[6:0]} : {1'h0, data[7:0]};
    case (psel)
      ucs_pkg::PSEL_ODD:  ucs_parity = ~^masked;
      ucs_pkg::PSEL_EVEN: ucs_parity = ^masked;
      ucs_pkg::PSEL_MARK: ucs_parity = 1'b1;
      default:            ucs_parity = 1'b0;
    endcase
  endfunction : ucs_parity

  function automatic logic [8:0] ucs_align(input logic [8:0] shift, input logic [3:0] nbits);
    case (nbits)
      ucs_pkg::NBITS_7: ucs_align = {2'h0, shift[8:2]};
      ucs_pkg::NBITS_8: ucs_align = {1'h0, shift[8:1]};
      default:          ucs_align = shift;
    endcase
  endfunction : ucs_align

  logic [3:0] nbits;
  logic       nine;
  logic       loop;
  logic       par_en;
  logic       sync;
  logic [3:0] last;
  logic       ck_stable;
  logic       ck_rise;
  logic       ck_fall;
  logic       din_stable;
  logic       rx_in;
  logic       tx_tick;
  logic       rx_tick;
  logic       tx_buf_wr;
  logic       do_load;
  logic       stop_last;
  logic [3:0] stop_end;
  logic [8:0] rx_data;
  logic       frame_done;
  logic       frm_err;
  logic       par_bad;

  always_comb begin
    st_d       = st_q;
    nbits      = ucs_nbits(st_q.flen);
    // parity is never used with nine data bits, the ninth bit takes its place
    nine       = st_q.flen[1];
    loop       = (st_q.flen == ucs_pkg::FLEN_LOOP);
    par_en     = st_q.par_en && !nine;
    sync       = st_q.cfg[ucs_pkg::CFG_SYNC];
    last       = sync ? ucs_pkg::SYNC_LAST : ucs_pkg::OVS_LAST;
    do_load    = 1'b0;
    frame_done = 1'b0;
    frm_err    = 1'b0;
    par_bad    = 1'b0;
    rx_data    = ucs_align(st_q.rx_shift, nbits);
    // short stop only trims the last stop bit, and only when oversampling
    stop_last  = (st_q.tx_stop_cnt == st_q.cfg[ucs_pkg::CFG_TWO_STOP]);
    stop_end   = (stop_last && st_q.cfg[ucs_pkg::CFG_SHORT_STOP] && !sync) ?
                 ucs_pkg::SHORT_LAST : last;

    // pin synchronisers
    st_d.ck_sync  = {st_q.ck_sync[1:0], serial_clock_pin_i};
    st_d.din_sync = {st_q.din_sync[1:0], serial_in_pin_i};
    ck_stable     = (st_q.ck_sync[1] == st_q.ck_sync[2]);
    din_stable    = (st_q.din_sync[1] == st_q.din_sync[2]);
    // an edge counts once the second and third stages agree, so a glitch is ignored
    ck_rise       = ck_stable && st_q.ck_sync[2] && !st_q.ck_lvl;
    ck_fall       = ck_stable && !st_q.ck_sync[2] && st_q.ck_lvl;
    if (ck_stable) begin
      st_d.ck_lvl = st_q.ck_sync[2];
    end
    if (din_stable) begin
      st_d.din_lvl = st_q.din_sync[2];
    end
    // loopback takes the transmit flop directly, no synchroniser on that path
    rx_in   = loop ? st_q.tx_out : st_q.din_lvl;
    tx_tick = st_q.cfg[ucs_pkg::CFG_TX_EXT] ? ck_rise : baud_tick_i;
    rx_tick = st_q.cfg[ucs_pkg::CFG_RX_EXT] ? (sync ? ck_fall : ck_rise) : baud_tick_i;

    // register writes
    tx_buf_wr = bus_i.wr && (bus_i.addr == ucs_pkg::ADDR_TX_BUF);
    if (tx_buf_wr) begin
      st_d.tx_buffer = bus_i.wdata;
      st_d.tx_empty  = 1'b0;
    end
    if (bus_i.wr && (bus_i.addr == ucs_pkg::ADDR_TX_CTRL)) begin
      st_d.par_en = bus_i.wdata[ucs_pkg::CTL_PAR_EN];
      st_d.psel1  = bus_i.wdata[ucs_pkg::CTL_PSEL1];
      st_d.xbit9  = bus_i.wdata[ucs_pkg::CTL_XBIT9];
      st_d.flen   = {bus_i.wdata[ucs_pkg::CTL_FLEN_HI], bus_i.wdata[ucs_pkg::CTL_FLEN_LO]};
    end
    if (bus_i.wr && (bus_i.addr == ucs_pkg::ADDR_RX_STAT)) begin
      st_d.spare = bus_i.wdata[ucs_pkg::STA_SPARE];
      st_d.attention_enable  = bus_i.wdata[ucs_pkg::STA_ATTENTION_ENABLE];
    end
    if (bus_i.wr && (bus_i.addr == ucs_pkg::ADDR_CFG)) begin
      st_d.cfg = bus_i.wdata;
    end

    // register reads and their side effects
    // read data stand for the one cycle after the strobe and are zero otherwise
    st_d.rdata = '0;
    if (bus_i.rd) begin
      case (bus_i.addr)
        ucs_pkg::ADDR_TX_BUF: begin
          st_d.rdata = st_q.tx_buffer;
        end
        ucs_pkg::ADDR_RX_BUF: begin
          st_d.rdata   = st_q.rx_buffer;
          st_d.rx_full = 1'b0;
        end
        ucs_pkg::ADDR_TX_CTRL: begin
          st_d.rdata[ucs_pkg::CTL_PAR_EN]   = st_q.par_en;
          st_d.rdata[ucs_pkg::CTL_PSEL1]    = st_q.psel1;
          st_d.rdata[ucs_pkg::CTL_XBIT9]    = st_q.xbit9;
          st_d.rdata[ucs_pkg::CTL_FLEN_HI]  = st_q.flen[1];
          st_d.rdata[ucs_pkg::CTL_FLEN_LO]  = st_q.flen[0];
          st_d.rdata[ucs_pkg::CTL_ERR]      = st_q.ovr | st_q.frm | st_q.par_err;
          st_d.rdata[ucs_pkg::CTL_RX_FULL]  = st_q.rx_full;
          st_d.rdata[ucs_pkg::CTL_TX_EMPTY] = st_q.tx_empty;
        end
        ucs_pkg::ADDR_RX_STAT: begin
          st_d.rdata[ucs_pkg::STA_OVR]     = st_q.ovr;
          st_d.rdata[ucs_pkg::STA_FRM]     = st_q.frm;
          st_d.rdata[ucs_pkg::STA_PAR]     = st_q.par_err;
          st_d.rdata[ucs_pkg::STA_SPARE]   = st_q.spare;
          st_d.rdata[ucs_pkg::STA_NINTH]   = st_q.ninth;
          st_d.rdata[ucs_pkg::STA_ATTENTION_ENABLE]    = st_q.attention_enable;
          st_d.rdata[ucs_pkg::STA_TX_ACT]  = st_q.tx_act;
          st_d.rdata[ucs_pkg::STA_RX_LINE] = st_q.rx_line;
          st_d.ovr     = 1'b0;
          st_d.frm     = 1'b0;
          st_d.par_err = 1'b0;
        end
        ucs_pkg::ADDR_CFG: begin
          st_d.rdata = st_q.cfg;
        end
        default: begin
          st_d.rdata = '0;
        end
      endcase
    end

    // transmitter
    case (st_q.tx_state)
      ucs_pkg::TX_IDLE: begin
        // a buffer write in this cycle defers the load, so write and load never clash
        do_load = !st_q.tx_empty && !tx_buf_wr;
      end
      ucs_pkg::TX_START: begin
        if (tx_tick) begin
          if (st_q.tx_sub == last) begin
            st_d.tx_sub     = '0;
            st_d.tx_bit_cnt = '0;
            st_d.tx_state   = ucs_pkg::TX_DATA;
          end else begin
            st_d.tx_sub = st_q.tx_sub + 4'h1;
          end
        end
      end
      ucs_pkg::TX_DATA: begin
        if (tx_tick) begin
          if (st_q.tx_sub == last) begin
            st_d.tx_sub     = '0;
            st_d.tx_shift   = {1'b1, st_q.tx_shift[8:1]};
            st_d.tx_bit_cnt = st_q.tx_bit_cnt + 4'h1;
            if (st_q.tx_bit_cnt == nbits - 4'h1) begin
              st_d.tx_stop_cnt = 1'b0;
              st_d.tx_state    = par_en ? ucs_pkg::TX_PAR : ucs_pkg::TX_STOP;
            end
          end else begin
            st_d.tx_sub = st_q.tx_sub + 4'h1;
          end
        end
      end
      ucs_pkg::TX_PAR: begin
        if (tx_tick) begin
          if (st_q.tx_sub == last) begin
            st_d.tx_sub   = '0;
            st_d.tx_state = ucs_pkg::TX_STOP;
          end else begin
            st_d.tx_sub = st_q.tx_sub + 4'h1;
          end
        end
      end
      ucs_pkg::TX_STOP: begin
        if (tx_tick) begin
          if (st_q.tx_sub == stop_end) begin
            st_d.tx_sub = '0;
            if (!stop_last) begin
              st_d.tx_stop_cnt = 1'b1;
            end else if (!st_q.tx_empty && !tx_buf_wr) begin
              do_load = 1'b1;
            end else begin
              st_d.tx_act   = 1'b0;
              st_d.tx_state = ucs_pkg::TX_IDLE;
            end
          end else begin
            st_d.tx_sub = st_q.tx_sub + 4'h1;
          end
        end
      end
      default: begin
        st_d.tx_state = ucs_pkg::TX_IDLE;
      end
    endcase
    // loading the shifter sets the empty flag again and starts a new frame
    if (do_load) begin
      st_d.tx_shift = {st_q.xbit9, st_q.tx_buffer};
      st_d.tx_par   = ucs_parity({st_q.psel1, st_q.xbit9}, {st_q.xbit9, st_q.tx_buffer}, nbits);
      st_d.tx_empty = 1'b1;
      st_d.tx_act   = 1'b1;
      st_d.tx_sub   = '0;
      st_d.tx_state = ucs_pkg::TX_START;
    end
    case (st_d.tx_state)
      ucs_pkg::TX_START: st_d.tx_out = 1'b0;
      ucs_pkg::TX_DATA:  st_d.tx_out = st_d.tx_shift[0];
      ucs_pkg::TX_PAR:   st_d.tx_out = st_d.tx_par;
      default:           st_d.tx_out = 1'b1;
    endcase

    // receiver
    case (st_q.rx_state)
      ucs_pkg::RX_IDLE: begin
        st_d.rx_sub     = '0;
        st_d.rx_bit_cnt = '0;
        if (!rx_in) begin
          if (!sync) begin
            st_d.rx_state = ucs_pkg::RX_START;
          end else if (rx_tick) begin
            st_d.rx_state = ucs_pkg::RX_DATA;
          end
        end
      end
      ucs_pkg::RX_START: begin
        if (rx_tick) begin
          if (st_q.rx_sub == ucs_pkg::HALF_LAST) begin
            st_d.rx_sub   = '0;
            // start bit is rechecked half a bit in; a short glitch returns to idle
            st_d.rx_state = rx_in ? ucs_pkg::RX_IDLE : ucs_pkg::RX_DATA;
          end else begin
            st_d.rx_sub = st_q.rx_sub + 4'h1;
          end
        end
      end
      ucs_pkg::RX_DATA: begin
        if (rx_tick) begin
          if (st_q.rx_sub == last) begin
            st_d.rx_sub     = '0;
            st_d.rx_shift   = {rx_in, st_q.rx_shift[8:1]};
            st_d.rx_bit_cnt = st_q.rx_bit_cnt + 4'h1;
            if (st_q.rx_bit_cnt == nbits - 4'h1) begin
              st_d.rx_state = par_en ? ucs_pkg::RX_PAR : ucs_pkg::RX_STOP;
            end
          end else begin
            st_d.rx_sub = st_q.rx_sub + 4'h1;
          end
        end
      end
      ucs_pkg::RX_PAR: begin
        if (rx_tick) begin
          if (st_q.rx_sub == last) begin
            st_d.rx_sub   = '0;
            st_d.rx_par   = rx_in;
            st_d.rx_state = ucs_pkg::RX_STOP;
          end else begin
            st_d.rx_sub = st_q.rx_sub + 4'h1;
          end
        end
      end
      ucs_pkg::RX_STOP: begin
        if (rx_tick) begin
          if (st_q.rx_sub == last) begin
            frame_done    = 1'b1;
            frm_err       = !rx_in;
            par_bad       = par_en && (st_q.rx_par != ucs_parity({st_q.psel1, st_q.xbit9}, rx_data, nbits));
            st_d.rx_state = ucs_pkg::RX_IDLE;
          end else begin
            st_d.rx_sub = st_q.rx_sub + 4'h1;
          end
        end
      end
      default: begin
        st_d.rx_state = ucs_pkg::RX_IDLE;
      end
    endcase

    // receive events; a set here wins over a clear above
    if (rx_in) begin
      st_d.rx_line = 1'b0;
    end
    if (frame_done) begin
      // overrun keeps the unread byte and drops the new one
      if (st_q.rx_full) begin
        st_d.ovr = 1'b1;
      end else begin
        st_d.rx_buffer = rx_data[7:0];
        st_d.rx_full   = 1'b1;
        if (nine) begin
          st_d.ninth = rx_data[8];
        end
      end
      if (nine && rx_data[8]) begin
        st_d.attention_enable = 1'b0;
      end
      if (frm_err) begin
        st_d.frm     = 1'b1;
        st_d.rx_line = 1'b1;
      end
      if (par_bad) begin
        st_d.par_err = 1'b1;
      end
    end
  end

  // reset leaves the line and the receive synchroniser at the idle high level
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st_q          <= '0;
      st_q.tx_state <= ucs_pkg::TX_IDLE;
      st_q.rx_state <= ucs_pkg::RX_IDLE;
      st_q.cfg      <= ucs_pkg::RST_CFG;
      st_q.tx_empty <= ucs_pkg::RST_TX_EMPTY;
      st_q.tx_out   <= 1'b1;
      st_q.ck_sync  <= '0;
      st_q.din_sync <= 3'h7;
      st_q.din_lvl  <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o             = st_q.rdata;
  assign serial_out_pin_o    = st_q.tx_out;
  assign serial_out_pin_oe_o = st_q.cfg[ucs_pkg::CFG_PIN_EN];
  // interrupt requests are plain levels of the flags and their enables
  assign rx_irq_o            = st_q.rx_full && st_q.cfg[ucs_pkg::CFG_RX_IE];
  assign tx_irq_o            = st_q.tx_empty && st_q.cfg[ucs_pkg::CFG_TX_IE];

endmodule : ucs_core

// ### bench/ucs_core_monitor.sv
// checker for the register port, pin enable and interrupt outputs of ucs_core
// assumes it is bound to ucs_core and sees only its ports
`timescale 1ns/1ns
module ucs_core_monitor (
  // clock and reset
  input wire logic                         core_clk_i,
  input wire logic                         srst_i,
  // register port
  input wire ucs_pkg::ucs_bus_req_s        bus_i,
  input wire logic [ucs_pkg::DATA_W-1:0]   rdata_o,
  // pins and requests
  input wire logic                         serial_out_pin_o,
  input wire logic                         serial_out_pin_oe_o,
  input wire logic                         rx_irq_o,
  input wire logic                         tx_irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  wire cfg_wr = bus_i.wr && bus_i.addr == ucs_pkg::ADDR_CFG;
  sequence s_stat_rd;
    bus_i.rd && bus_i.addr == ucs_pkg::ADDR_RX_STAT;
  endsequence
  a_reset_quiet: assert property (
    $fell(srst_i) |-> rdata_o == 8'h00 && serial_out_pin_o && !serial_out_pin_oe_o && !rx_irq_o && !tx_irq_o)
    else $error("outputs not quiet after reset");
  a_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
    else $error("read data without a read");
  a_txie_off: assert property (cfg_wr && !bus_i.wdata[ucs_pkg::CFG_TX_IE] |=> !tx_irq_o)
    else $error("tx irq with enable cleared");
  a_rxie_off: assert property (cfg_wr && !bus_i.wdata[ucs_pkg::CFG_RX_IE] |=> !rx_irq_o)
    else $error("rx irq with enable cleared");
  a_tx_gate: assert property (
    $past(bus_i.rd && bus_i.addr == ucs_pkg::ADDR_TX_CTRL) && !rdata_o[ucs_pkg::CTL_TX_EMPTY] |-> !$past(tx_irq_o))
    else $error("tx irq without empty flag");
  a_rx_gate: assert property (
    $past(bus_i.rd && bus_i.addr == ucs_pkg::ADDR_TX_CTRL) && !rdata_o[ucs_pkg::CTL_RX_FULL] |-> !$past(rx_irq_o))
    else $error("rx irq without full flag");
  a_pin_follow: assert property (
    cfg_wr |-> ##2 serial_out_pin_oe_o == $past(bus_i.wdata[ucs_pkg::CFG_PIN_EN], 2))
    else $error("pin enable does not follow config");
  a_err_clear: assert property (s_stat_rd ##2 s_stat_rd |=> rdata_o[7:5] == 3'h0)
    else $error("error flags survive status read");
  a_buf_clear: assert property (bus_i.rd && bus_i.addr == ucs_pkg::ADDR_RX_BUF |=> !rx_irq_o)
    else $error("rx irq after buffer read");
endmodule : ucs_core_monitor
bind ucs_core ucs_core_monitor u_mon (.core_clk_i(core_clk_i), .srst_i(srst_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .serial_out_pin_o(serial_out_pin_o), .serial_out_pin_oe_o(serial_out_pin_oe_o), .rx_irq_o(rx_irq_o),
  .tx_irq_o(tx_irq_o));

// ### bench/ucs_serial_peer.sv
// remote serial station: sends frames on the receive pin and catches frames from the transmit pin
// assumes a fixed bit time in core clock cycles and an idle high line
`timescale 1ns/1ns
module ucs_serial_peer #(parameter int BIT_CYC = 32) (
  // clock
  input wire logic core_clk_i,
  // line
  input wire logic line_in_i,
  output logic     line_out_o
);
  initial line_out_o = 1'b1;
  // start, n data bits lsb first, then a good or a bad stop bit
  task automatic send(input logic [8:0] d, input int n, input logic stop);
    @(posedge core_clk_i) line_out_o <= 1'b0;
    repeat (BIT_CYC) @(posedge core_clk_i);
    for (int i = 0; i < n; i++) begin
      line_out_o <= d[i];
      repeat (BIT_CYC) @(posedge core_clk_i);
    end
    line_out_o <= stop;
    repeat (stop ? BIT_CYC : BIT_CYC / 2 + 4) @(posedge core_clk_i);
  endtask : send
  task automatic idle;
    @(posedge core_clk_i) line_out_o <= 1'b1;
  endtask : idle
  task automatic catch_frame(input int n, output logic [8:0] d, output logic ok);
    d = '0;
    for (int t = 0; t < 4000 && line_in_i; t++) @(posedge core_clk_i);
    repeat (BIT_CYC / 2) @(posedge core_clk_i);
    for (int i = 0; i < n; i++) begin
      repeat (BIT_CYC) @(posedge core_clk_i);
      d[i] = line_in_i;
    end
    repeat (BIT_CYC) @(posedge core_clk_i);
    ok = line_in_i;
  endtask : catch_frame
endmodule : ucs_serial_peer

// ### bench/testbench.sv
// self-checking bench for ucs_core with a remote serial station on the pins
// assumes a baud tick every second cycle, so one async bit is 32 cycles
`timescale 1ns/1ns
module testbench;
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] m; logic [7:0] e;} ucs_row_s;
  localparam ucs_row_s ROWS [7] = '{'{8'hbc, 8'ha5, 8'hff, 8'ha5}, '{8'hbc, 8'h5a, 8'hff, 8'h5a},
    '{8'hbb, 8'hef, 8'hff, 8'h04}, '{8'h00, 8'hff, 8'hff, 8'h00}, '{8'hba, 8'hff, 8'hff, 8'hf9},
    '{8'hbc, 8'h01, 8'hff, 8'h01}, '{8'hba, 8'h00, 8'hff, 8'h01}};
  logic                  core_clk = 1'b0;
  logic                  srst     = 1'b1;
  logic                  baud_tick = 1'b0;
  ucs_pkg::ucs_bus_req_s bus_req  = '0;
  logic [7:0]            rdata;
  logic                  rx_line;
  logic                  sout;
  logic                  sout_oe;
  logic                  rx_irq;
  logic                  tx_irq;
  wire                   tx_pin = sout_oe ? sout : 1'b1;
  int                    num_errors = 0;
  int                    n_checks = 0;
  int                    cyc = 0;
  logic [8:0]            f;
  logic                  ok;
  ucs_core uut (.core_clk_i(core_clk), .srst_i(srst), .bus_i(bus_req), .rdata_o(rdata), .baud_tick_i(baud_tick),
    .serial_in_pin_i(rx_line), .serial_clock_pin_i(1'b0), .serial_out_pin_o(sout), .serial_out_pin_oe_o(sout_oe),
    .rx_irq_o(rx_irq), .tx_irq_o(tx_irq));
  ucs_serial_peer #(.BIT_CYC(32)) peer (.core_clk_i(core_clk), .line_in_i(tx_pin), .line_out_o(rx_line));
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    baud_tick <= ~baud_tick;
    if (cyc == 30000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge core_clk) bus_req <= '{a, w, 1'b1, 1'b0};
    @(posedge core_clk) bus_req <= '0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge core_clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk) bus_req <= '0;
    #1 chk({1'b0, rdata & m}, {1'b0, e});
  endtask : rc
  task automatic reset_check;
    @(posedge core_clk) srst <= 1'b1;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    rc(8'hba, 8'hff, 8'h01);
    rc(8'hbb, 8'hff, 8'h00);
    rc(8'hbc, 8'hff, 8'h00);
  endtask : reset_check
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  initial begin
    reset_check();
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].w);
      rc(ROWS[i].a, ROWS[i].m, ROWS[i].e);
    end
    chk(tx_irq, 1'b1);
    wr(8'hbc, 8'h20);
    for (int k = 0; k < 3; k++) begin
      wr(8'hba, {3'b001, k[1:0] == 2'd0 ? 2'h0 : k[1:0] == 2'd1 ? 2'h1 : 2'h2, 3'b000});
      fork
        peer.catch_frame(k == 1 ? 7 : k == 2 ? 9 : 8, f, ok);
        wr(8'hb8, 8'hc5 ^ 8'(k));
      join
      chk(f, {1'b1, 8'hc5 ^ 8'(k)} & ((9'h1 << (k == 1 ? 7 : k == 2 ? 9 : 8)) - 9'h1));
      chk(ok, 1'b1);
    end
    wr(8'hbc, 8'ha0);
    wr(8'hba, 8'h80);
    fork
      peer.catch_frame(9, f, ok);
      wr(8'hb8, 8'h5a);
    join
    chk(f, 9'h15a);
    chk(ok, 1'b1);
    repeat (24) @(posedge core_clk);
    rc(8'hbb, 8'h02, 8'h02);
    repeat (40) @(posedge core_clk);
    rc(8'hbb, 8'h02, 8'h00);
    wr(8'hb8, 8'h11);
    wr(8'hb8, 8'h22);
    rc(8'hba, 8'h01, 8'h00);
    repeat (800) @(posedge core_clk);
    rc(8'hba, 8'h01, 8'h01);
    wr(8'hba, 8'h10);
    wr(8'hbc, 8'h02);
    peer.send(9'h1c3, 9, 1'b1);
    chk(rx_irq, 1'b1);
    rc(8'hbb, 8'h0c, 8'h08);
    peer.send(9'h055, 9, 1'b1);
    rc(8'hba, 8'h06, 8'h06);
    rc(8'hbb, 8'he0, 8'h80);
    rc(8'hb9, 8'hff, 8'hc3);
    rc(8'hba, 8'h02, 8'h00);
    peer.send(9'h0aa, 9, 1'b0);
    rc(8'hbb, 8'h41, 8'h41);
    peer.idle();
    repeat (40) @(posedge core_clk);
    rc(8'hbb, 8'he1, 8'h00);
    rc(8'hbb, 8'he0, 8'h00);
    rc(8'hb9, 8'hff, 8'haa);
    wr(8'hba, 8'h80);
    peer.send(9'h05a, 9, 1'b1);
    rc(8'hbb, 8'h20, 8'h20);
    rc(8'hb9, 8'hff, 8'h5a);
    wr(8'hba, 8'h38);
    wr(8'hb8, 8'h96);
    repeat (420) @(posedge core_clk);
    rc(8'hbb, 8'h08, 8'h08);
    rc(8'hb9, 8'hff, 8'h96);
    reset_check();
    stop_test();
  end
endmodule : testbench
